/* pkg/cangc_pkg.sv */
// Constants, field layouts and reset values for the negotiation register slice.
// Assumes one pclk domain; indices are word indices, byte address is four times index.
package cangc_pkg;
    localparam int ADDR_W = 10;
    localparam int IDX_W = 8;
    localparam logic [IDX_W-1:0] IDX_EXP = 8'h06;
    localparam logic [IDX_W-1:0] IDX_NPT = 8'h07;
    localparam logic [IDX_W-1:0] IDX_LPNP = 8'h08;
    localparam logic [IDX_W-1:0] IDX_GIG = 8'h09;
    localparam int EXP_PDF = 4;
    localparam int EXP_LPNP = 3;
    localparam int EXP_LNP = 2;
    localparam int EXP_PR = 1;
    localparam int EXP_LPAN = 0;
    localparam int EXP_RSV_LO = 5;
    localparam logic EXP_LNP_RST = 1'h1;
    localparam int NPT_RSV = 14;
    localparam int NPT_TOG = 11;
    localparam logic [15:0] NPT_RST = 16'h2001;
    localparam logic [15:0] NPT_WMASK = 16'hB7FF;
    localparam logic [15:0] LPNP_RST = 16'h0000;
    localparam int GIG_TM_HI = 15;
    localparam int GIG_TM_LO = 13;
    localparam int GIG_MAN = 12;
    localparam int GIG_VAL = 11;
    localparam int GIG_PORT = 10;
    localparam int GIG_FD = 9;
    localparam int GIG_HD = 8;
    localparam logic [15:0] GIG_RST = 16'h0300;
    typedef enum logic [2:0] {
        TM_NORMAL = 3'h0,
        TM_WAVEFORM = 3'h1,
        TM_JIT_MASTER = 3'h2,
        TM_JIT_SLAVE = 3'h3,
        TM_DISTORTION = 3'h4
    } cangc_tmode_type;
endpackage

/* pkg/cangc_reg_if.sv */
// Register access carrier between the APB port and the register slice.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
`default_nettype none
interface cangc_reg_if;
    import cangc_pkg::*;
    logic [IDX_W-1:0] idx;
    logic [15:0] wdata;
    logic acc_wr;
    logic acc_rd;
    logic [15:0] rdata;
    logic hit;
    modport port (output idx, output wdata, output acc_wr, output acc_rd,
                  input rdata, input hit);
    modport regs (input idx, input wdata, input acc_wr, input acc_rd,
                  output rdata, output hit);
endinterface
`default_nettype wire

/* hw/cangc_apb_port.sv */
// APB slave front end: decode, zero-wait answer, registered read data.
// Assumes an APB3 master on pclk; no byte strobes.
`timescale 1ns/1ps
`default_nettype none
module cangc_apb_port
    import cangc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    cangc_reg_if.port bus
);
    typedef struct packed {
        logic [31:0] prdata;
    } cangc_port_st_type;

    cangc_port_st_type r;
    cangc_port_st_type n;
    logic access;

    assign access = psel & penable;
    assign bus.idx = paddr[ADDR_W-1:2];
    assign bus.wdata = pwdata[15:0];
    assign bus.acc_wr = access & pwrite & bus.hit;
    // Read strobe at the capture edge, so a read clear cannot drop a later event
    assign bus.acc_rd = psel & ~penable & ~pwrite & bus.hit;
    // Zero wait states; unmapped words answer with an error
    assign pready = access;
    assign pslverr = access & ~bus.hit;
    assign prdata = r.prdata;

    // Read data captured in setup so it leaves a flop in the access phase
    always_comb
    begin
        n = r;
        if (psel & ~penable & ~pwrite)
        begin
            n.prdata = bus.hit ? {16'h0000, bus.rdata} : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end
endmodule
`default_nettype wire

/* hw/cangc_regs.sv */
// Negotiation expansion, next page and gigabit control register slice.
// Assumes negotiation event inputs are one-cycle pulses synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module cangc_regs
    import cangc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sw_reset,
    input wire logic restart_an,
    input wire logic power_up,
    input wire logic link_fail,
    input wire logic pd_fault,
    input wire logic page_rx,
    input wire logic [15:0] rx_code_word,
    input wire logic lp_np_able,
    input wire logic lp_an_able,
    input wire logic tx_toggle,
    input wire logic np_taken,
    output logic np_loaded,
    output logic [15:0] tx_code_word,
    output logic [2:0] test_mode,
    output logic tx_clk_from_rx,
    output logic ms_manual,
    output logic ms_master,
    output logic port_pref_master,
    output logic adv_1000_fd,
    output logic adv_1000_hd
);
    typedef struct packed {
        logic pdf_lh;
        logic pr_lh;
        logic lp_np;
        logic lp_an;
        logic [15:0] npt;
        logic toggle;
        logic np_loaded;
        logic [15:0] lpnp;
        logic [15:0] gig_sw;
        logic [4:0] gig_live;
        logic [2:0] tmode;
        logic tx_clk_rx;
        logic pref_master;
    } cangc_state_type;

    cangc_reg_if bus ();

    cangc_state_type r;
    cangc_state_type n;
    logic rd_exp;
    logic wr_npt;
    logic wr_gig;
    logic apply;
    logic [15:0] gig_now;

    // Set beats clear so an event in the clearing cycle is kept
    function automatic logic cangc_sticky(input logic cur, input logic set, input logic clr);
        cangc_sticky = set | (cur & ~clr);
    endfunction

    cangc_apb_port u_port (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .bus(bus.port)
    );

    assign rd_exp = bus.acc_rd & (bus.idx == IDX_EXP);
    assign wr_npt = bus.acc_wr & (bus.idx == IDX_NPT);
    assign wr_gig = bus.acc_wr & (bus.idx == IDX_GIG);
    assign apply = sw_reset | restart_an | power_up | link_fail;
    assign bus.hit = (bus.idx == IDX_EXP) | (bus.idx == IDX_NPT) |
                     (bus.idx == IDX_LPNP) | (bus.idx == IDX_GIG);

    always_comb
    begin
        bus.rdata = 16'h0000;
        case (bus.idx)
            IDX_EXP:
            begin
                bus.rdata[EXP_PDF] = r.pdf_lh;
                bus.rdata[EXP_LPNP] = r.lp_np;
                bus.rdata[EXP_LNP] = EXP_LNP_RST;
                bus.rdata[EXP_PR] = r.pr_lh;
                bus.rdata[EXP_LPAN] = r.lp_an;
            end
            IDX_NPT:
            begin
                bus.rdata = r.npt;
                bus.rdata[NPT_TOG] = r.toggle;
            end
            IDX_LPNP:
            begin
                bus.rdata = r.lpnp;
            end
            IDX_GIG:
            begin
                bus.rdata = r.gig_sw;
            end
            default:
            begin
                bus.rdata = 16'h0000;
            end
        endcase
    end

    always_comb
    begin
        n = r;
        gig_now = r.gig_sw;
        // Reading the expansion word clears the latched bits
        n.pdf_lh = cangc_sticky(r.pdf_lh, pd_fault, rd_exp);
        n.pr_lh = cangc_sticky(r.pr_lh, page_rx, rd_exp);
        n.lp_np = lp_np_able;
        n.lp_an = lp_an_able;
        n.toggle = tx_toggle;
        if (page_rx)
        begin
            n.lpnp = rx_code_word;
        end
        if (wr_npt)
        begin
            n.npt = bus.wdata & NPT_WMASK;
        end
        n.np_loaded = cangc_sticky(r.np_loaded, wr_npt, np_taken);
        if (wr_gig)
        begin
            gig_now = bus.wdata;
        end
        if (restart_an)
        begin
            gig_now[GIG_TM_HI:GIG_TM_LO] = TM_NORMAL;
        end
        n.gig_sw = gig_now;
        // Duplex and role bits stay parked until a renegotiation event
        if (apply)
        begin
            n.gig_live = gig_now[GIG_MAN:GIG_HD];
        end
        if (link_fail)
        begin
            n.npt = 16'h0000;
            n.np_loaded = 1'b0;
        end
        if (sw_reset)
        begin
            n.pdf_lh = 1'b0;
            n.pr_lh = 1'b0;
            n.npt = NPT_RST;
            n.np_loaded = 1'b0;
            n.lpnp = LPNP_RST;
        end
        // Reserved codes fall back to normal operation
        case (gig_now[GIG_TM_HI:GIG_TM_LO])
            TM_NORMAL, TM_WAVEFORM, TM_JIT_MASTER, TM_JIT_SLAVE, TM_DISTORTION:
            begin
                n.tmode = gig_now[GIG_TM_HI:GIG_TM_LO];
            end
            default:
            begin
                n.tmode = TM_NORMAL;
            end
        endcase
        n.tx_clk_rx = (n.tmode == TM_JIT_MASTER) | (n.tmode == TM_JIT_SLAVE);
        n.pref_master = n.gig_live[GIG_PORT-GIG_HD] & ~n.gig_live[GIG_MAN-GIG_HD];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r.pdf_lh <= 1'b0;
            r.pr_lh <= 1'b0;
            r.lp_np <= 1'b0;
            r.lp_an <= 1'b0;
            r.npt <= NPT_RST;
            r.toggle <= 1'b0;
            r.np_loaded <= 1'b0;
            r.lpnp <= LPNP_RST;
            r.gig_sw <= GIG_RST;
            r.gig_live <= GIG_RST[GIG_MAN:GIG_HD];
            r.tmode <= TM_NORMAL;
            r.tx_clk_rx <= 1'b0;
            r.pref_master <= 1'b0;
        end
        else
        begin
            r <= n;
        end
    end

    assign np_loaded = r.np_loaded;
    assign tx_code_word = {r.npt[15:12], r.toggle, r.npt[10:0]};
    assign test_mode = r.tmode;
    assign tx_clk_from_rx = r.tx_clk_rx;
    assign ms_manual = r.gig_live[GIG_MAN-GIG_HD];
    assign ms_master = r.gig_live[GIG_VAL-GIG_HD];
    assign port_pref_master = r.pref_master;
    assign adv_1000_fd = r.gig_live[GIG_FD-GIG_HD];
    assign adv_1000_hd = r.gig_live[GIG_HD-GIG_HD];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_exp_reserved_zero: assert property (
        (bus.idx == IDX_EXP) |-> (bus.rdata[15:EXP_RSV_LO] == 11'h000))
        else $error("expansion reserved bits not zero");
    a_fault_latched: assert property (
        pd_fault && !sw_reset |=> r.pdf_lh ##1 (r.pdf_lh || $past(rd_exp) || $past(sw_reset)))
        else $error("fault flag not latched");
    a_page_latched: assert property (
        page_rx && !sw_reset |=> r.pr_lh && (r.lpnp == $past(rx_code_word)))
        else $error("page received not latched");
    a_partner_caps: assert property (
        ##1 (r.lp_np == $past(lp_np_able)) && (r.lp_an == $past(lp_an_able)))
        else $error("partner capability mismatch");
    a_local_np_one: assert property (
        (bus.idx == IDX_EXP) |-> bus.rdata[EXP_LNP])
        else $error("local next page bit not one");
    a_np_loaded_set: assert property (
        wr_npt && !link_fail && !sw_reset |=> np_loaded)
        else $error("next page loaded not flagged");
    a_link_fail_clear: assert property (
        link_fail && !sw_reset |=> (r.npt == 16'h0000) && !np_loaded)
        else $error("link fail did not clear transmit word");
    a_npt_rsv_zero: assert property (
        !tx_code_word[NPT_RSV])
        else $error("reserved transmit bit set");
    a_tm_restart_clear: assert property (
        restart_an |=> test_mode == TM_NORMAL)
        else $error("restart did not clear test mode");
    a_jitter_clock: assert property (
        tx_clk_from_rx == ((test_mode == TM_JIT_MASTER) || (test_mode == TM_JIT_SLAVE)))
        else $error("jitter clock select wrong");
    a_gig_parked: assert property (
        !apply |=> $stable(r.gig_live))
        else $error("gigabit control applied without event");
    a_port_ignored: assert property (
        ms_manual |-> !port_pref_master)
        else $error("port preference used under manual mode");
    a_lh_read_clear: assert property (
        rd_exp && !pd_fault && !page_rx |=> !r.pdf_lh && !r.pr_lh)
        else $error("latched bits not cleared by read");
    // Per-field update and hold checks
    a_lh_sw_clear: assert property (
        sw_reset |=> !r.pdf_lh && !r.pr_lh)
        else $error("software reset left latched bits set");
    a_fault_hold: assert property (
        r.pdf_lh && !rd_exp && !sw_reset |=> r.pdf_lh)
        else $error("fault flag dropped without read");
    a_page_hold: assert property (
        r.pr_lh && !rd_exp && !sw_reset |=> r.pr_lh)
        else $error("page flag dropped without read");
    a_fault_no_spur: assert property (
        !r.pdf_lh && !pd_fault |=> !r.pdf_lh)
        else $error("fault flag set without fault");
    a_page_no_spur: assert property (
        !r.pr_lh && !page_rx |=> !r.pr_lh)
        else $error("page flag set without page");
    a_lpnp_hold: assert property (
        !page_rx && !sw_reset |=> $stable(r.lpnp))
        else $error("received word changed without page");
    a_lpnp_sw_clear: assert property (
        sw_reset |=> r.lpnp == LPNP_RST)
        else $error("received word not reset");
    a_npt_write: assert property (
        wr_npt && !link_fail && !sw_reset |=> r.npt == ($past(bus.wdata) & NPT_WMASK))
        else $error("transmit word write wrong");
    a_npt_hold: assert property (
        !wr_npt && !link_fail && !sw_reset |=> $stable(r.npt))
        else $error("transmit word changed without cause");
    a_npt_sw_reset: assert property (
        sw_reset |=> (r.npt == NPT_RST) && !np_loaded)
        else $error("transmit word not reset");
    a_toggle_follow: assert property (
        ##1 (tx_code_word[NPT_TOG] == $past(tx_toggle)))
        else $error("toggle bit not from negotiation");
    a_np_taken_clear: assert property (
        np_taken && !wr_npt |=> !np_loaded)
        else $error("loaded flag not cleared when taken");
    a_np_hold: assert property (
        np_loaded && !np_taken && !link_fail && !sw_reset |=> np_loaded)
        else $error("loaded flag dropped early");
    a_tm_decode: assert property (
        test_mode == ((r.gig_sw[GIG_TM_HI:GIG_TM_LO] > TM_DISTORTION) ?
                      TM_NORMAL : r.gig_sw[GIG_TM_HI:GIG_TM_LO]))
        else $error("test mode decode wrong");
    a_tm_sw_keep: assert property (
        sw_reset && !restart_an && !wr_gig |=> $stable(test_mode))
        else $error("software reset changed test mode");
    a_gig_apply: assert property (
        apply |=> r.gig_live == r.gig_sw[GIG_MAN:GIG_HD])
        else $error("gigabit bits not applied on event");
    a_gig_view: assert property (
        wr_gig && !restart_an |=> r.gig_sw == $past(bus.wdata))
        else $error("gigabit readback not updated");
    a_pref_auto: assert property (
        !ms_manual |-> port_pref_master == r.gig_live[GIG_PORT-GIG_HD])
        else $error("port preference not applied");
    a_manual_applied: assert property (
        apply |=> ms_manual == r.gig_sw[GIG_MAN])
        else $error("manual select not applied");
    a_role_applied: assert property (
        apply |=> ms_master == r.gig_sw[GIG_VAL])
        else $error("forced role not applied");
    a_duplex_applied: assert property (
        apply |=> (adv_1000_fd == r.gig_sw[GIG_FD]) && (adv_1000_hd == r.gig_sw[GIG_HD]))
        else $error("duplex advertisement not applied");
    a_partner_an: assert property (
        ##1 (r.lp_an == $past(lp_an_able)))
        else $error("partner negotiation ability mismatch");
    a_exp_lh_bits: assert property (
        (bus.idx == IDX_EXP) |-> (bus.rdata[EXP_PR] == r.pr_lh) && (bus.rdata[EXP_PDF] == r.pdf_lh))
        else $error("latched bits misplaced in expansion word");
    a_exp_caps_bits: assert property (
        (bus.idx == IDX_EXP) |-> (bus.rdata[EXP_LPNP] == r.lp_np) && (bus.rdata[EXP_LPAN] == r.lp_an))
        else $error("partner bits misplaced in expansion word");
    a_tm_write: assert property (
        wr_gig && !restart_an && (bus.wdata[GIG_TM_HI:GIG_TM_LO] == TM_WAVEFORM) |=> test_mode == TM_WAVEFORM)
        else $error("written test mode not applied");

    c_fault_read: cover property (pd_fault ##[1:20] rd_exp);
    c_np_write_link_fail: cover property (wr_npt ##[1:20] link_fail);
    c_gig_apply: cover property (wr_gig ##[1:20] restart_an);
    c_jitter_mode: cover property (tx_clk_from_rx);
    c_manual_apply: cover property (apply ##1 ms_manual);
endmodule
`default_nettype wire

/* verification/cangc_partner.sv */
// Remote link partner and negotiation side: sends pages, consumes loaded next pages.
// Assumes the bench commands each page with a one-cycle send pulse on pclk.
`timescale 1ns/1ps
`default_nettype none
module cangc_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic send,
    input wire logic [15:0] page_word,
    input wire logic [3:0] take_dly,
    input wire logic np_loaded,
    input wire logic link_lost,
    output logic page_rx,
    output logic [15:0] rx_code_word,
    output logic lp_np_able,
    output logic lp_an_able,
    output logic tx_toggle,
    output logic np_taken
);
    logic [3:0] wait_cnt;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            page_rx <= 1'b0;
            rx_code_word <= 16'h0000;
            lp_np_able <= 1'b0;
            lp_an_able <= 1'b0;
            tx_toggle <= 1'b0;
            np_taken <= 1'b0;
            wait_cnt <= 4'h0;
        end
        else
        begin
            page_rx <= send;
            // Word only meaningful with page_rx; scramble it otherwise
            rx_code_word <= send ? page_word : ~rx_code_word;
            if (send)
            begin
                lp_np_able <= page_word[15];
                lp_an_able <= 1'b1;
            end
            np_taken <= 1'b0;
            // A lost link restarts the exchange, so the toggle starts over
            if (link_lost)
            begin
                tx_toggle <= 1'b0;
                wait_cnt <= 4'h0;
            end
            // Slow or prompt take-up of the loaded page, per take_dly
            else if (np_loaded && !np_taken)
            begin
                if (wait_cnt == take_dly)
                begin
                    np_taken <= 1'b1;
                    tx_toggle <= ~tx_toggle;
                    wait_cnt <= 4'h0;
                end
                else
                    wait_cnt <= wait_cnt + 4'h1;
            end
            // No count left over from a page dropped before take-up
            else
            begin
                wait_cnt <= 4'h0;
            end
        end
    end
endmodule
`default_nettype wire

/* verification/cangc_regs_tb_top.sv */
// Register-level bench for the negotiation register slice over APB.
// Assumes zero or more wait states; events are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module cangc_regs_tb_top
    import cangc_pkg::*;
;
    localparam logic [9:0] A_EXP = {IDX_EXP, 2'b00};
    localparam logic [9:0] A_NPT = {IDX_NPT, 2'b00};
    localparam logic [9:0] A_LPNP = {IDX_LPNP, 2'b00};
    localparam logic [9:0] A_GIG = {IDX_GIG, 2'b00};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, send = 0, err;
    logic [9:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, page_rx, lp_np_able, lp_an_able, tx_toggle, np_taken;
    logic np_loaded, tx_clk_from_rx, ms_manual, ms_master, port_pref_master;
    logic adv_1000_fd, adv_1000_hd;
    logic [4:0] ev = '0;
    logic [15:0] rx_code_word, tx_code_word, page_word = '0;
    logic [3:0] take_dly = 4'h5;
    logic [2:0] test_mode;
    logic [4:0] ap;
    logic [15:0] gv [4] = '{16'h1C00, 16'h0600, 16'h1100, 16'h0300};
    int miscompares = 0, checks = 0;
    cangc_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .sw_reset(ev[0]), .restart_an(ev[1]), .power_up(ev[2]),
        .link_fail(ev[3]), .pd_fault(ev[4]), .page_rx, .rx_code_word, .lp_np_able,
        .lp_an_able, .tx_toggle, .np_taken, .np_loaded, .tx_code_word, .test_mode,
        .tx_clk_from_rx, .ms_manual, .ms_master, .port_pref_master, .adv_1000_fd,
        .adv_1000_hd);
    cangc_partner partner (.pclk, .presetn, .send, .page_word, .take_dly, .np_loaded,
        .link_lost(ev[3]),
        .page_rx, .rx_code_word, .lp_np_able, .lp_an_able, .tx_toggle, .np_taken);
    initial
    begin
        forever #2 pclk = ~pclk;
    end
    task automatic results();
        $display("Checks %0d, miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [9:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            miscompares++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [9:0] a, input logic [15:0] e);
        apb(1'b0, a, 16'h0000);
        check(rd, {16'h0000, e});
    endtask
    task automatic pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev <= '0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic send_page(input logic [15:0] w);
        @(posedge pclk);
        page_word <= w;
        send <= 1'b1;
        @(posedge pclk);
        send <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    initial
    begin
        int n;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(A_EXP, 16'h0004);
        rd_chk(A_NPT, 16'h2001);
        rd_chk(A_LPNP, 16'h0000);
        rd_chk(A_GIG, 16'h0300);
        rd_chk(10'h028, 16'h0000);
        check(err, 1'b1);
        $display("Test reset values done");
        apb(1'b1, A_NPT, 16'hFFFF);
        @(posedge pclk);
        check(np_loaded, 1'b1);
        rd_chk(A_NPT, 16'hB7FF);
        n = 0;
        while (np_loaded !== 1'b0 && n < 40)
        begin
            @(posedge pclk);
            n++;
        end
        @(posedge pclk);
        check(tx_code_word, 16'hB7FF | {4'h0, tx_toggle, 11'h000});
        pulse(3);
        rd_chk(A_NPT, 16'h0000);
        check({np_loaded, tx_code_word}, 17'h0_0000);
        apb(1'b1, A_NPT, 16'h1234);
        pulse(0);
        rd_chk(A_NPT, 16'h2001);
        $display("Test next page transmit done");
        send_page(16'hC123);
        rd_chk(A_LPNP, 16'hC123);
        rd_chk(A_EXP, 16'h000F);
        rd_chk(A_EXP, 16'h000D);
        send_page(16'h0ABC);
        rd_chk(A_EXP, 16'h0007);
        pulse(4);
        rd_chk(A_EXP, 16'h0015);
        rd_chk(A_EXP, 16'h0005);
        $display("Test expansion status done");
        ap = 5'b00011;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, A_GIG, gv[i]);
            @(posedge pclk);
            check({ms_manual, ms_master, port_pref_master, adv_1000_fd, adv_1000_hd}, ap);
            rd_chk(A_GIG, gv[i]);
            pulse(i);
            ap = {gv[i][12], gv[i][11], gv[i][10] & ~gv[i][12], gv[i][9], gv[i][8]};
            check({ms_manual, ms_master, port_pref_master, adv_1000_fd, adv_1000_hd}, ap);
        end
        $display("Test gigabit apply done");
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, A_GIG, {c[2:0], 13'h0300});
            @(posedge pclk);
            check({test_mode, tx_clk_from_rx}, {(c < 5) ? c[2:0] : 3'h0, c == 2 || c == 3});
        end
        apb(1'b1, A_GIG, 16'h6300);
        pulse(0);
        rd_chk(A_GIG, 16'h6300);
        pulse(1);
        rd_chk(A_GIG, 16'h0300);
        check(test_mode, 3'h0);
        pulse(0);
        $display("Test mode field done");
        results();
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        results();
    end
endmodule
`default_nettype wire
